// ### hdl/lsq_pkg.sv
// Purpose: Shared types and constants for the load/arith/store sequencer.
// Assumes: Octal timing steps 00..27 are held as indices 0..23.
// Notes:   Opcode values are octal opcodes written in hex.
package lsq_pkg;

	// ==========================================================
	// Timing steps (index of octal step)
	localparam logic [4:0] STEP_00 = 5'h00;
	localparam logic [4:0] STEP_05 = 5'h05;
	localparam logic [4:0] STEP_06 = 5'h06;
	localparam logic [4:0] STEP_07 = 5'h07;
	localparam logic [4:0] STEP_10 = 5'h08;
	localparam logic [4:0] STEP_12 = 5'h0a;
	localparam logic [4:0] STEP_13 = 5'h0b;
	localparam logic [4:0] STEP_15 = 5'h0d;
	localparam logic [4:0] STEP_16 = 5'h0e;
	localparam logic [4:0] STEP_20 = 5'h10;
	localparam logic [4:0] STEP_21 = 5'h11;
	localparam logic [4:0] STEP_22 = 5'h12;
	localparam logic [4:0] STEP_23 = 5'h13;
	localparam logic [4:0] STEP_24 = 5'h14;
	localparam logic [4:0] STEP_25 = 5'h15;
	localparam logic [4:0] STEP_26 = 5'h16;
	localparam logic [4:0] STEP_27 = 5'h17;
	localparam logic [4:0] STEP_RST = 5'h00;

	// ==========================================================
	// Opcodes (6-bit function field)
	localparam int OPC_W = 6;
	localparam logic [5:0] LOAD_IMMEDIATE_OP   = 6'h10;
	localparam logic [5:0] LOAD_MEMORY_OP      = 6'h11;
	localparam logic [5:0] LOAD_INDIRECT_OP    = 6'h12;
	localparam logic [5:0] NEGLOAD_MEMORY_OP   = 6'h15;
	localparam logic [5:0] NEGLOAD_INDIRECT_OP = 6'h16;
	localparam logic [5:0] SUM_IMMEDIATE_OP    = 6'h18;
	localparam logic [5:0] SUM_MEMORY_OP       = 6'h19;
	localparam logic [5:0] SUM_INDIRECT_OP     = 6'h1a;
	localparam logic [5:0] MINUS_IMMEDIATE_OP  = 6'h1c;
	localparam logic [5:0] MINUS_MEMORY_OP     = 6'h1d;
	localparam logic [5:0] MINUS_INDIRECT_OP   = 6'h1e;
	localparam logic [5:0] SAVE_MEMORY_OP      = 6'h21;
	localparam logic [5:0] SAVE_INDIRECT_OP    = 6'h22;

	// ==========================================================
	// Register map (byte addresses) and reset values
	localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
	localparam logic [31:0] ADDR_TAG    = 32'h0000_0004;
	localparam logic [31:0] ADDR_ACC    = 32'h0000_0008;
	localparam logic [31:0] ADDR_PC     = 32'h0000_000c;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_CYC_LSB = 0;
	localparam int STAT_STEP_LSB = 4;
	localparam int STAT_FUNC_LSB = 9;
	localparam int STAT_PROBED_BIT = 15;
	localparam logic CTRL_RUN_RST = 1'b0;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {CYC_FETCH, CYC_IND, CYC_ADDR, CYC_EXEC} lsq_cyc_e;
	typedef enum logic [2:0] {
		CLS_LOAD, CLS_NLOAD, CLS_ADD, CLS_SUB, CLS_STORE, CLS_NONE
	} lsq_cls_e;
	typedef enum logic [1:0] {FORM_NONE, FORM_DIRECT, FORM_INDIRECT} lsq_form_e;

	typedef struct packed {
		lsq_cls_e  cls;
		lsq_form_e form;
	} lsq_dec_s;

	typedef struct packed {
		logic core_read_flop;
		logic core_write_flop;
		logic core_inhibit_flop;
		logic core_divert_flop;
	} lsq_core_ctl_s;

endpackage

// ### hdl/lsq_sequencer.sv
// Purpose: Main-cycle sequencer for load, add, subtract and store.
// Assumes: Core memory senses the word at mem_addr during reads.
// Notes:   Registers on APB; zero wait states, one's complement adder.
// Operation
// - Opcodes 20, 21, 22 load accumulator: no-address, direct, indirect.
// - Opcodes 25, 26 load the negated operand, direct and indirect.
// - Opcodes 30, 31, 32 add: no-address, direct, indirect.
// - Opcodes 34, 35, 36 subtract: no-address, direct, indirect.
// - Opcodes 41, 42 store accumulator, direct and indirect.
// - Fetch: advance counter, clear address at 00; counter to address at 05.
// - Step 07 of every cycle except store execute saves the program counter.
// - Fetch: read set, exchange cleared at 10; sense in 12; read off 15.
// - Fetch: function cleared at 13; inhibit set, exchange to function 16.
// - Fetch: divert set 06, write set 20, divert off 26, rest off 27.
// - Loads after fetch: no-address execute, direct address, else indirect.
// - Store after fetch: direct to address cycle, indirect to execute.
// - Indirect cycle steps counter, fetches word, then goes to address.
// - Address cycle loads address at 05, reads at 12, then execute.
// - Store execute: exchange plus tag address, accumulator to exchange.
// - Add or subtract gate accumulator and signed operand, result to A.
// - No-address execute addresses from counter, others from exchange+tag.
// - Load execute gates operand, clear 21, toggle 23, probe 24, move 25.
`timescale 1ns/10ps
module lsq_sequencer #(
	parameter int WORD_W = 12
)
(
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Core memory stack
	output logic [WORD_W-1:0]          mem_addr,
	output logic [WORD_W-1:0]          mem_wdata,
	input  wire logic [WORD_W-1:0]     memory_sense_word,
	output lsq_pkg::lsq_core_ctl_s     core_ctl
);
	import lsq_pkg::*;

	// ==========================================================
	// State
	logic [4:0]        step;
	logic              adv;
	logic              last;
	logic              run;
	lsq_cyc_e          cyc;
	lsq_cyc_e          next_cyc;
	lsq_dec_s          dec;
	logic [OPC_W-1:0]  func;
	logic [WORD_W-1:0] xreg;
	logic [WORD_W-1:0] working_program_counter;
	logic [WORD_W-1:0] saved_program_counter;
	logic [WORD_W-1:0] acc;
	logic [WORD_W-1:0] tag;
	logic [WORD_W-1:0] q_in;
	logic [WORD_W-1:0] r_in;
	logic [WORD_W-1:0] ares;
	logic              probed;
	logic [WORD_W-1:0] pc_inc;
	logic              is_arith;
	logic              wr_en;
	logic              rd_setup;
	logic              mapped;
	logic [31:0]       next_prdata;

	// ==========================================================
	// Helpers
	function automatic lsq_dec_s decode(input logic [OPC_W-1:0] op);
		lsq_dec_s d;
		d.cls  = CLS_NONE;
		d.form = FORM_NONE;
		case (op)
			LOAD_IMMEDIATE_OP:   d = '{CLS_LOAD, FORM_NONE};
			LOAD_MEMORY_OP:      d = '{CLS_LOAD, FORM_DIRECT};
			LOAD_INDIRECT_OP:    d = '{CLS_LOAD, FORM_INDIRECT};
			NEGLOAD_MEMORY_OP:   d = '{CLS_NLOAD, FORM_DIRECT};
			NEGLOAD_INDIRECT_OP: d = '{CLS_NLOAD, FORM_INDIRECT};
			SUM_IMMEDIATE_OP:    d = '{CLS_ADD, FORM_NONE};
			SUM_MEMORY_OP:       d = '{CLS_ADD, FORM_DIRECT};
			SUM_INDIRECT_OP:     d = '{CLS_ADD, FORM_INDIRECT};
			MINUS_IMMEDIATE_OP:  d = '{CLS_SUB, FORM_NONE};
			MINUS_MEMORY_OP:     d = '{CLS_SUB, FORM_DIRECT};
			MINUS_INDIRECT_OP:   d = '{CLS_SUB, FORM_INDIRECT};
			SAVE_MEMORY_OP:      d = '{CLS_STORE, FORM_DIRECT};
			SAVE_INDIRECT_OP:    d = '{CLS_STORE, FORM_INDIRECT};
			default:             d = '{CLS_NONE, FORM_NONE};
		endcase
		return d;
	endfunction

	// True only on the edge that issues step s of cycle c
	function automatic logic at(input lsq_cyc_e c, input logic [4:0] s);
		return adv && (cyc == c) && (step == s);
	endfunction

	// One's complement sum with end-around carry
	function automatic logic [WORD_W-1:0] oc_add(
		input logic [WORD_W-1:0] a,
		input logic [WORD_W-1:0] b);
		logic [WORD_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return WORD_W'(s[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, s[WORD_W]});
	endfunction

	assign dec      = decode(func);
	assign is_arith = (dec.cls == CLS_ADD) || (dec.cls == CLS_SUB);
	assign pc_inc   = WORD_W'(working_program_counter + 1'b1);

	// ==========================================================
	// Timing chain
	lsq_step_chain u_chain
	(
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.run     (run),
		.step    (step),
		.adv     (adv),
		.last    (last)
	);

	// Next cycle choice, looked at only at step 27
	always_comb
	begin
		next_cyc = CYC_FETCH;
		case (cyc)
			CYC_FETCH:
				if (dec.cls == CLS_NONE)
					next_cyc = CYC_FETCH; // Unknown opcodes act as no-ops
				else if (dec.form == FORM_NONE)
					next_cyc = CYC_EXEC;
				else if (dec.form == FORM_DIRECT)
					next_cyc = CYC_ADDR;
				else if (dec.cls == CLS_STORE)
					next_cyc = CYC_EXEC;
				else
					next_cyc = CYC_IND;
			CYC_IND:  next_cyc = CYC_ADDR;
			CYC_ADDR: next_cyc = CYC_EXEC;
			default:  next_cyc = CYC_FETCH;
		endcase
	end

	// Single encoded cycle flag keeps exactly one cycle active
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			cyc <= CYC_FETCH;
		else if (adv && last)
			cyc <= next_cyc;
	end

	// ==========================================================
	// Program counters
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			working_program_counter <= '0;
		else if (at(CYC_FETCH, STEP_00) || at(CYC_IND, STEP_00) ||
			(at(CYC_ADDR, STEP_00) && dec.form == FORM_DIRECT) ||
			(at(CYC_EXEC, STEP_00) && dec.form == FORM_NONE && is_arith) ||
			(at(CYC_EXEC, STEP_00) && dec.form == FORM_NONE))
			working_program_counter <= pc_inc;
		else if (wr_en && paddr == ADDR_PC)
			working_program_counter <= pwdata[WORD_W-1:0];
	end

	// Store execute has no save step
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			saved_program_counter <= '0;
		else if (adv && step == STEP_07 &&
			!(cyc == CYC_EXEC && dec.cls == CLS_STORE))
			saved_program_counter <= working_program_counter;
	end

	// ==========================================================
	// Storage address register
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			mem_addr <= '0;
		else if (adv && step == STEP_00)
			mem_addr <= '0;
		else if (adv && step == STEP_05)
		begin
			if (cyc == CYC_FETCH || cyc == CYC_IND)
				mem_addr <= working_program_counter;
			else if (cyc == CYC_ADDR)
				mem_addr <= (dec.form == FORM_DIRECT) ?
					working_program_counter : xreg;
			else if (dec.form == FORM_NONE && dec.cls != CLS_STORE)
				mem_addr <= working_program_counter;
			else
				mem_addr <= WORD_W'(xreg + tag);
		end
	end

	// ==========================================================
	// Exchange and function registers
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			xreg <= '0;
		else if (adv && step == STEP_10)
			xreg <= '0;
		else if (adv && step == STEP_12)
			xreg <= (cyc == CYC_EXEC && dec.cls == CLS_STORE) ?
				acc : memory_sense_word;
	end

	// Write-back data for the restore follows the exchange register
	assign mem_wdata = xreg;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			func <= '0;
		else if (at(CYC_FETCH, STEP_13))
			func <= '0;
		else if (at(CYC_FETCH, STEP_16))
			func <= xreg[WORD_W-1 -: OPC_W];
	end

	// ==========================================================
	// Core control flip-flops, driven in fetch only
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			core_ctl <= '0;
		else
		begin
			if (at(CYC_FETCH, STEP_06))
				core_ctl.core_divert_flop <= 1'b1;
			else if (at(CYC_FETCH, STEP_26))
				core_ctl.core_divert_flop <= 1'b0;
			if (at(CYC_FETCH, STEP_10))
				core_ctl.core_read_flop <= 1'b1;
			else if (at(CYC_FETCH, STEP_15))
				core_ctl.core_read_flop <= 1'b0;
			if (at(CYC_FETCH, STEP_16))
				core_ctl.core_inhibit_flop <= 1'b1;
			else if (at(CYC_FETCH, STEP_27))
				core_ctl.core_inhibit_flop <= 1'b0;
			if (at(CYC_FETCH, STEP_20))
				core_ctl.core_write_flop <= 1'b1;
			else if (at(CYC_FETCH, STEP_27))
				core_ctl.core_write_flop <= 1'b0;
		end
	end

	// ==========================================================
	// Adder inputs, held from step 15 through 25
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			q_in <= '0;
			r_in <= '0;
		end
		else if (at(CYC_EXEC, STEP_15))
		begin
			q_in <= is_arith ? acc : '0;
			r_in <= (dec.cls == CLS_NLOAD || dec.cls == CLS_SUB) ?
				~xreg : xreg;
		end
	end

	// Add/subtract run one step earlier than load and store
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			ares   <= '0;
			probed <= 1'b0;
		end
		else if (at(CYC_EXEC, STEP_21))
		begin
			ares   <= '0;
			probed <= 1'b0;
		end
		else if (at(CYC_EXEC, is_arith ? STEP_22 : STEP_23))
			ares <= oc_add(q_in, r_in);
		else if (at(CYC_EXEC, is_arith ? STEP_23 : STEP_24))
			probed <= 1'b1;
	end

	// Hardware transfer wins over a software write in the same cycle
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			acc <= '0;
		else if (probed && at(CYC_EXEC, is_arith ? STEP_24 : STEP_25))
			acc <= ares;
		else if (wr_en && paddr == ADDR_ACC)
			acc <= pwdata[WORD_W-1:0];
	end

	// ==========================================================
	// APB slave: zero wait states, read data captured in setup
	assign pready   = psel && penable;
	assign wr_en    = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign mapped   = (paddr == ADDR_CTRL) || (paddr == ADDR_TAG) ||
		(paddr == ADDR_ACC) || (paddr == ADDR_PC) ||
		(paddr == ADDR_STATUS);
	assign pslverr  = pready && !mapped;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			run <= CTRL_RUN_RST;
			tag <= '0;
		end
		else if (wr_en && paddr == ADDR_CTRL)
			run <= pwdata[CTRL_RUN_BIT];
		else if (wr_en && paddr == ADDR_TAG)
			tag <= pwdata[WORD_W-1:0];
	end

	// Unmapped reads return zero
	always_comb
	begin
		next_prdata = '0;
		if (paddr == ADDR_CTRL)
			next_prdata[CTRL_RUN_BIT] = run;
		else if (paddr == ADDR_TAG)
			next_prdata[WORD_W-1:0] = tag;
		else if (paddr == ADDR_ACC)
			next_prdata[WORD_W-1:0] = acc;
		else if (paddr == ADDR_PC)
			next_prdata[WORD_W-1:0] = working_program_counter;
		else if (paddr == ADDR_STATUS)
		begin
			next_prdata[STAT_CYC_LSB +: 4] = 4'h1 << cyc;
			next_prdata[STAT_STEP_LSB +: 5] = step;
			next_prdata[STAT_FUNC_LSB +: OPC_W] = func;
			next_prdata[STAT_PROBED_BIT] = probed;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			prdata <= '0;
		else if (rd_setup)
			prdata <= next_prdata;
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence seq_fetch_at(logic [4:0] s);
		adv && cyc == CYC_FETCH && step == s;
	endsequence

	sequence seq_fetch_end_with(lsq_cls_e c, lsq_form_e f);
		seq_fetch_at(STEP_27) ##0 (dec.cls == c && dec.form == f);
	endsequence

	AST_PC_ADVANCE: assert property (
		seq_fetch_at(STEP_00) |=> working_program_counter == $past(pc_inc))
		else $error("counter not advanced at fetch step 00");
	AST_ADDR_FROM_PC: assert property (
		seq_fetch_at(STEP_05) |=> mem_addr == $past(working_program_counter))
		else $error("address not loaded from counter at 05");
	AST_SAVE_STEP: assert property (
		$changed(saved_program_counter) |-> $past(step) == STEP_07 &&
		saved_program_counter == $past(working_program_counter))
		else $error("saved counter changed off step 07");
	AST_READ_SET: assert property (
		$rose(core_ctl.core_read_flop) |->
			$past(step) == STEP_10 && $past(cyc) == CYC_FETCH)
		else $error("read flop set off fetch step 10");
	AST_READ_CLR: assert property (
		$fell(core_ctl.core_read_flop) |-> $past(step) == STEP_15)
		else $error("read flop cleared off step 15");
	AST_FUNC_LOAD: assert property (
		seq_fetch_at(STEP_16) |=> func == $past(xreg[WORD_W-1 -: OPC_W]) &&
			core_ctl.core_inhibit_flop)
		else $error("function or inhibit wrong after step 16");
	AST_WRITE_SET: assert property (
		$rose(core_ctl.core_write_flop) |-> $past(step) == STEP_20)
		else $error("write flop set off step 20");
	AST_DIVERT_CLR: assert property (
		$fell(core_ctl.core_divert_flop) |-> $past(step) == STEP_26)
		else $error("divert flop cleared off step 26");
	AST_LOAD_ROUTE: assert property (
		seq_fetch_end_with(CLS_LOAD, FORM_DIRECT) |=> cyc == CYC_ADDR)
		else $error("direct load not sent to address cycle");
	AST_STORE_IND: assert property (
		seq_fetch_end_with(CLS_STORE, FORM_INDIRECT) |=> cyc == CYC_EXEC)
		else $error("indirect store not sent to execute");
	AST_CYC_CHANGE: assert property (
		$changed(cyc) |-> $past(last) && $past(adv) && step == STEP_00)
		else $error("cycle changed away from step 27 boundary");
	AST_ACC_XFER: assert property (
		(at(CYC_EXEC, STEP_25) && probed && !is_arith) |=>
			acc == $past(ares))
		else $error("result not moved to accumulator at 25");

endmodule

// ### hdl/lsq_step_chain.sv
// Purpose: Timing chain stepping through the steps of one memory cycle.
// Assumes: run gates the chain; it holds its step while stopped.
// Notes:   last marks step 27, where the next cycle is chosen.
`timescale 1ns/10ps
module lsq_step_chain
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Control
	input  wire logic        run,
	// Timing
	output logic [4:0]       step,
	output logic             adv,
	output logic             last
);
	import lsq_pkg::*;

	// A step counts as issued on the edge that leaves it
	assign adv  = run;
	assign last = (step == STEP_27);

	// Wrap after the twenty-fourth step
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			step <= STEP_RST;
		else if (run)
			step <= last ? STEP_00 : 5'(step + 5'h01);
	end

endmodule

// ### verif/lsq_core_mem.sv
// Purpose: Core memory stack model facing the sequencer.
// Assumes: Word width matches the sequencer; bench preloads the array.
// Notes:   Sense follows the address at once; restore writes back.
`timescale 1ns/10ps
module lsq_core_mem #(
	parameter int WORD_W = 12
)
(
	// Clock
	input  wire logic                   ref_clk,
	// Sequencer side
	input  wire logic [WORD_W-1:0]      mem_addr,
	input  wire logic [WORD_W-1:0]      mem_wdata,
	input  wire lsq_pkg::lsq_core_ctl_s core_ctl,
	output logic [WORD_W-1:0]           memory_sense_word
);
	import lsq_pkg::*;

	// ==========================================================
	// Storage
	logic [WORD_W-1:0] mem [0:(1<<WORD_W)-1];

	// Sense is always offered: the sequencer samples it in every cycle except store execute,
	// not only while the read flop is set
	assign memory_sense_word = mem[mem_addr];

	// Restore phase writes the exchange word back into the stack
	always @(posedge ref_clk)
		if (core_ctl.core_write_flop && core_ctl.core_inhibit_flop)
			mem[mem_addr] <= mem_wdata;
endmodule

// ### verif/lsq_sequencer_bench.sv
// Purpose: Self-checking bench for the load/arith/store sequencer.
// Assumes: Zero-wait APB slave; run stop freezes the timing chain.
// Notes:   Instruction runs are timed in whole cycles of 24 steps.
`timescale 1ns/10ps
module lsq_sequencer_bench;
	import lsq_pkg::*;

	// ==========================================================
	// Signals and constants
	localparam int W = 12;
	localparam logic [W-1:0] P0 = 12'h010;
	localparam logic [W-1:0] A0 = 12'hc23;
	localparam logic [W-1:0] DV = 12'h6a5;
	localparam logic [W-1:0] IV = 12'h7f0;
	typedef struct packed {
		logic [5:0] opc;
		logic [2:0] kind;
		logic [1:0] form;
		logic [2:0] ncyc;
		logic [2:0] dpc;
	} lsq_row_s;
	logic          ref_clk;
	logic          sys_rst;
	logic          psel;
	logic          penable;
	logic          pwrite;
	logic [31:0]   paddr;
	logic [31:0]   pwdata;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	logic [W-1:0]  mem_addr;
	logic [W-1:0]  mem_wdata;
	logic [W-1:0]  memory_sense_word;
	lsq_core_ctl_s core_ctl;
	logic [31:0]   rd;
	logic          er;
	logic [W-1:0]  v;
	logic [W-1:0]  e;
	lsq_row_s      r;
	int            bad_count = 0;
	int            n_checks = 0;
	int            cyc = 0;
	int            fl_cnt [4];
	// Kind 0 load, 1 negload, 2 add, 3 sub, 4 store, 5 none
	lsq_row_s rows [14] = '{
		'{LOAD_IMMEDIATE_OP, 3'd0, 2'd0, 3'd2, 3'd2},
		'{LOAD_MEMORY_OP, 3'd0, 2'd1, 3'd3, 3'd2},
		'{LOAD_INDIRECT_OP, 3'd0, 2'd2, 3'd4, 3'd2},
		'{NEGLOAD_MEMORY_OP, 3'd1, 2'd1, 3'd3, 3'd2},
		'{NEGLOAD_INDIRECT_OP, 3'd1, 2'd2, 3'd4, 3'd2},
		'{SUM_IMMEDIATE_OP, 3'd2, 2'd0, 3'd2, 3'd2},
		'{SUM_MEMORY_OP, 3'd2, 2'd1, 3'd3, 3'd2},
		'{SUM_INDIRECT_OP, 3'd2, 2'd2, 3'd4, 3'd2},
		'{MINUS_IMMEDIATE_OP, 3'd3, 2'd0, 3'd2, 3'd2},
		'{MINUS_MEMORY_OP, 3'd3, 2'd1, 3'd3, 3'd2},
		'{MINUS_INDIRECT_OP, 3'd3, 2'd2, 3'd4, 3'd2},
		'{SAVE_MEMORY_OP, 3'd4, 2'd1, 3'd3, 3'd2},
		'{SAVE_INDIRECT_OP, 3'd4, 2'd2, 3'd2, 3'd1},
		'{6'h3f, 3'd5, 2'd0, 3'd1, 3'd1}
	};

	// ==========================================================
	// Design and partner
	lsq_sequencer #(.WORD_W(W)) lsq_sequencer_inst
	(
		.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.memory_sense_word(memory_sense_word), .core_ctl(core_ctl)
	);
	lsq_core_mem #(.WORD_W(W)) lsq_core_mem_inst
	(
		.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.core_ctl(core_ctl), .memory_sense_word(memory_sense_word)
	);

	// ==========================================================
	// Clock, timeout and core flop monitor
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Counts high cycles of each core flop; widths expose step slips
	always @(posedge ref_clk)
	begin
		cyc++;
		for (int i = 0; i < 4; i++)
			if (core_ctl[i] === 1'b1)
				fl_cnt[i]++;
		if (cyc == 20000)
		begin
			bad_count++;
			end_sim();
		end
	end

	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] ex, got);
		n_checks++;
		if (got !== ex)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// One APB transfer; holds the request until pready is sampled high
	task automatic bus(input logic wr, input logic [31:0] a, d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Chain advances on n edges: the stop write commits on the last one
	task automatic run_steps(input int n);
		bus(1'b1, ADDR_CTRL, 32'h1);
		repeat (n - 3) @(posedge ref_clk);
		bus(1'b1, ADDR_CTRL, 32'h0);
	endtask
	function automatic logic [W-1:0] oadd(input logic [W-1:0] a, b);
		logic [W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[W-1:0] + {{(W-1){1'b0}}, s[W]};
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		sys_rst = 1'b1;
		lsq_core_mem_inst.mem[P0 + 2] = 12'h040;
		lsq_core_mem_inst.mem[12'h040] = 12'h050;
		lsq_core_mem_inst.mem[12'h043] = DV;
		lsq_core_mem_inst.mem[12'h053] = IV;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		bus(1'b0, ADDR_STATUS, 0);
		chk("status_rst", 32'h1, rd);
		bus(1'b0, 32'h40, 0);
		chk("unmapped", 32'h1, {rd[30:0], er});
		bus(1'b1, ADDR_TAG, 32'h3);
		for (int i = 0; i < 14; i++)
		begin
			r = rows[i];
			lsq_core_mem_inst.mem[P0 + 1] = {r.opc, 6'h00};
			bus(1'b1, ADDR_PC, {20'h0, P0});
			bus(1'b1, ADDR_ACC, {20'h0, A0});
			fl_cnt = '{default: 0};
			run_steps(r.ncyc * 24);
			v = (r.form == 2'd0) ? 12'h040 : (r.form == 2'd1) ? DV : IV;
			case (r.kind)
				3'd0: e = v;
				3'd1: e = ~v;
				3'd2: e = oadd(A0, v);
				3'd3: e = oadd(A0, ~v);
				default: e = A0;
			endcase
			bus(1'b0, ADDR_ACC, 0);
			chk("acc", {20'h0, e}, rd);
			bus(1'b0, ADDR_PC, 0);
			chk("pc", {20'h0, P0 + r.dpc}, rd);
			bus(1'b0, ADDR_STATUS, 0);
			chk("status", {r.opc, 9'h001}, {17'h0, rd[14:0]});
			chk("slverr", 32'h0, {31'h0, er});
			chk("read_w", 32'd5, fl_cnt[3]);
			chk("write_w", 32'd7, fl_cnt[2]);
			chk("inh_w", 32'd9, fl_cnt[1]);
			chk("div_w", 32'd16, fl_cnt[0]);
			if (r.kind == 3'd4)
			begin
				e = (r.form == 2'd1) ? 12'h043 : {r.opc, 6'h00} + 12'h3;
				chk("st_addr", {20'h0, e}, {20'h0, mem_addr});
				chk("st_data", {20'h0, A0}, {20'h0, mem_wdata});
			end
		end
		// Stop in mid-fetch: chain must hold its step while stopped
		lsq_core_mem_inst.mem[P0 + 1] = 12'hfc0;
		bus(1'b1, ADDR_PC, {20'h0, P0});
		run_steps(10);
		bus(1'b0, ADDR_STATUS, 0);
		chk("frz_a", 32'ha1, {23'h0, rd[8:0]});
		repeat (20) @(posedge ref_clk);
		bus(1'b0, ADDR_STATUS, 0);
		chk("frz_b", 32'ha1, {23'h0, rd[8:0]});
		run_steps(14);
		bus(1'b0, ADDR_STATUS, 0);
		chk("wrap", 32'h1, {23'h0, rd[8:0]});
		// Reset in mid-run returns to a stopped fetch at step 00
		bus(1'b1, ADDR_CTRL, 32'h1);
		repeat (30) @(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		bus(1'b0, ADDR_STATUS, 0);
		chk("status_rst2", 32'h1, rd);
		bus(1'b0, ADDR_CTRL, 0);
		chk("ctrl_rst2", 32'h0, rd);
		end_sim();
	end
endmodule
